// ===== dv/slpp_far.sv
/*
  slpp_far: strap resistors on green lamp pins 1:0, sense pull-ups.
  assumes: oe_n high means the block has released the pin.
*/
module slpp_far (
  input  wire logic [3:0] i_lamp,
  input  wire logic [3:0] i_lamp_oe_n,
  input  wire logic [1:0] i_strap,
  input  wire logic [3:0] i_oc_cmd,
  output logic      [1:0] o_pin,
  output logic      [3:0] o_sense_low
);
  timeunit 1ns;
  timeprecision 100ps;
  // released pin shows its strap level
  assign o_pin = (i_lamp_oe_n[1:0] & i_strap) | (~i_lamp_oe_n[1:0] & i_lamp[1:0]);
  // monitor pulls low on over-current, pull-up otherwise
  assign o_sense_low = ~i_oc_cmd;
endmodule : slpp_far

// ===== dv/slpp_top_props.sv
/*
  slpp_top_props: port checks of reset, lamp drive, power, bus.
  assumes: bound to slpp_top, straps steady around release.
*/
module slpp_top_props (
  input wire logic       i_clk_sys,
  input wire logic       i_sys_rst,
  input wire logic       o_awready,
  input wire logic       o_wready,
  input wire logic       o_bvalid,
  input wire logic       i_bready,
  input wire logic       i_arvalid,
  input wire logic       o_arready,
  input wire logic       o_rvalid,
  input wire logic       i_rready,
  input wire logic       i_power_polarity_strap,
  input wire logic [3:0] o_green_port_lamp_oe_n,
  input wire logic [3:0] o_ownership_lamp_oe_n,
  input wire logic [3:0] o_port_power_enable
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_sys_rst);
  logic cap;
  logic pol_q;
  // first edge after release captures
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cap <= 1'b0;
    end else begin
      cap <= 1'b1;
      if (!cap) begin
        pol_q <= i_power_polarity_strap;
      end
    end
  end
  AST_PWR_RST: assert property (disable iff (1'b0)
    i_sys_rst |-> o_port_power_enable == {4{~i_power_polarity_strap}})
    else $error("port power active in reset");
  AST_PWR_CAP: assert property (disable iff (1'b0)
    !cap |-> o_port_power_enable == {4{~i_power_polarity_strap}})
    else $error("port power active before strap capture");
  AST_OE_RST: assert property (disable iff (1'b0)
    i_sys_rst |-> &{o_green_port_lamp_oe_n, o_ownership_lamp_oe_n})
    else $error("lamp pin driven in reset");
  AST_OE_HOLD: assert property ($rose(cap) |->
    &{o_green_port_lamp_oe_n, o_ownership_lamp_oe_n})
    else $error("lamp pin driven at capture");
  AST_OE_DRIVE: assert property (cap && $past(cap) |->
    {o_green_port_lamp_oe_n, o_ownership_lamp_oe_n} == 8'h00)
    else $error("lamp pin not driven");
  AST_PWR_IDLE: assert property ($rose(cap) |->
    o_port_power_enable == {4{~pol_q}})
    else $error("port power wrong after release");
  AST_RD_LAT: assert property (i_arvalid && o_arready |=> o_rvalid)
    else $error("read answer late");
  AST_R_DONE: assert property (o_rvalid && i_rready |=> !o_rvalid)
    else $error("read answer repeated");
  AST_B_DONE: assert property (o_bvalid && i_bready |=> !o_bvalid)
    else $error("write answer repeated");
  AST_B_BLOCK: assert property (o_bvalid |-> !o_awready && !o_wready)
    else $error("write taken during answer");
  AST_R_BLOCK: assert property (o_rvalid |-> !o_arready)
    else $error("read taken during answer");
  COV_WR: cover property (o_bvalid && i_bready);
  COV_RD: cover property (o_rvalid && i_rready);
  COV_BOOT: cover property ($rose(cap));
endmodule : slpp_top_props

bind slpp_top slpp_top_props u_props (
  .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .o_awready(o_awready),
  .o_wready(o_wready), .o_bvalid(o_bvalid), .i_bready(i_bready),
  .i_arvalid(i_arvalid), .o_arready(o_arready), .o_rvalid(o_rvalid),
  .i_rready(i_rready), .i_power_polarity_strap(i_power_polarity_strap),
  .o_green_port_lamp_oe_n(o_green_port_lamp_oe_n),
  .o_ownership_lamp_oe_n(o_ownership_lamp_oe_n),
  .o_port_power_enable(o_port_power_enable)
);

// ===== dv/slpp_top_tb.sv
/*
  slpp_top_tb: bus tasks, strap, lamp, power and over-current runs.
  assumes: slpp_far stands on lamp and sense pins.
*/
module slpp_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        i_clk_sys = 1'b0;
  logic        i_sys_rst = 1'b0;
  logic [7:0]  i_awaddr = 8'h00, i_araddr = 8'h00;
  logic [31:0] i_wdata = 32'h0000_0000;
  logic [3:0]  i_wstrb = 4'hf, oc_cmd = 4'h0;
  logic        i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
  logic        i_arvalid = 1'b0, i_rready = 1'b0, i_power_polarity_strap = 1'b0;
  logic [1:0]  strap = 2'h0, fx, act, o_bresp, o_rresp;
  logic [2:0]  i_config_method_strap = 3'h0, cf;
  logic [2:0]  nrm [4] = '{3'h0, 3'h1, 3'h3, 3'h7};
  logic        pl, dflt, o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_irq;
  logic [31:0] o_rdata;
  logic [3:0]  o_green_port_lamp, o_green_port_lamp_oe_n, o_ownership_lamp;
  logic [3:0]  o_ownership_lamp_oe_n, o_port_power_enable;
  wire logic [1:0] i_fixed_device_strap;
  wire logic [3:0] i_overcurrent_sense_low;
  int          failures = 0, comparisons = 0, cycles = 0;

  slpp_top dut (.*);
  slpp_far u_far (.i_lamp(o_green_port_lamp), .i_lamp_oe_n(o_green_port_lamp_oe_n),
    .i_strap(strap), .i_oc_cmd(oc_cmd), .o_pin(i_fixed_device_strap),
    .o_sense_low(i_overcurrent_sense_low));

  initial begin
    forever #12.5 i_clk_sys = ~i_clk_sys;
  end

  task automatic wrap_up();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    i_awaddr <= a;
    i_wdata <= d;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    do begin
      @(posedge i_clk_sys);
      if (o_awready) i_awvalid <= 1'b0;
      if (o_wready) i_wvalid <= 1'b0;
    end while (!o_bvalid);
    i_bready <= 1'b0;
    chk("bresp", 32'(o_bresp), 32'(er));
    repeat (2) @(posedge i_clk_sys);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    i_araddr <= a;
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    do begin
      @(posedge i_clk_sys);
      if (o_arready) i_arvalid <= 1'b0;
    end while (!o_rvalid);
    i_rready <= 1'b0;
    chk("rdata", o_rdata, ed);
    chk("rresp", 32'(o_rresp), 32'(er));
    @(posedge i_clk_sys);
  endtask : rd

  task automatic boot(input logic [1:0] f, input logic [2:0] c, input logic p);
    i_sys_rst <= 1'b1;
    strap <= f;
    i_config_method_strap <= c;
    i_power_polarity_strap <= p;
    repeat (8) @(posedge i_clk_sys);
    chk("pwr_rst", 32'(o_port_power_enable), 32'({4{~p}}));
    chk("oe_rst", 32'({o_green_port_lamp_oe_n, o_ownership_lamp_oe_n}), 32'h0000_00ff);
    i_sys_rst <= 1'b0;
    repeat (4) @(posedge i_clk_sys);
  endtask : boot

  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      wrap_up();
    end
  end

  initial begin
    for (int k = 0; k < 10; k++) begin
      fx = (k < 4) ? 2'(k) : 2'h1;
      cf = (k < 4) ? 3'h0 : 3'(k - 4);
      pl = k[0];
      dflt = (cf == 3'h0) || (cf == 3'h2) || (cf == 3'h4);
      act = dflt ? fx : 2'h3;
      boot(fx, cf, pl);
      rd(slpp_pkg::OFF_STATUS, {21'h0, cf, 2'h0, pl, dflt ? nrm[fx] : 3'h0,
        dflt ? fx : 2'h0}, 2'h0);
      chk("green", 32'(o_green_port_lamp), 32'({2'h3, act}));
      chk("pwr", 32'(o_port_power_enable), 32'({4{~pl}}));
    end
    wr(slpp_pkg::OFF_OWNER, 32'h0000_00e4, 2'h0);
    chk("dual", 32'({o_green_port_lamp, o_ownership_lamp}), 32'h0000_0053);
    boot(2'h0, slpp_pkg::CFG_DEFAULT_SC, 1'b1);
    wr(slpp_pkg::OFF_OWNER, 32'h0000_00e4, 2'h0);
    chk("single", 32'({o_green_port_lamp, o_ownership_lamp}), 32'h0000_00eb);
    wr(slpp_pkg::OFF_POWER, 32'h0000_000f, 2'h0);
    i_power_polarity_strap <= 1'b0;
    oc_cmd <= 4'h4;
    repeat (4) @(posedge i_clk_sys);
    chk("pwr_cut", 32'(o_port_power_enable), 32'h0000_000b);
    rd(slpp_pkg::OFF_IRQ_STATUS, 32'h0000_0004, 2'h0);
    rd(slpp_pkg::OFF_STATUS, 32'h0000_4420, 2'h0);
    chk("irq_masked", 32'(o_irq), 32'h0000_0000);
    wr(slpp_pkg::OFF_IRQ_MASK, 32'h0000_0004, 2'h0);
    chk("irq", 32'(o_irq), 32'h0000_0001);
    oc_cmd <= 4'h0;
    wr(slpp_pkg::OFF_IRQ_STATUS, 32'h0000_0004, 2'h0);
    chk("irq_clr", 32'(o_irq), 32'h0000_0000);
    chk("pwr_on", 32'(o_port_power_enable), 32'h0000_000f);
    boot(2'h0, slpp_pkg::CFG_DEFAULT_3W, 1'b0);
    rd(slpp_pkg::OFF_CTRL, 32'h0000_0003, 2'h0);
    rd(slpp_pkg::OFF_OWNER, 32'h0000_0000, 2'h0);
    rd(slpp_pkg::OFF_IRQ_MASK, 32'h0000_0000, 2'h0);
    wr(8'h20, 32'hffff_ffff, 2'h2);
    rd(8'h20, 32'h0000_0000, 2'h2);
    wr(slpp_pkg::OFF_STATUS, 32'hffff_ffff, 2'h0);
    rd(slpp_pkg::OFF_STATUS, 32'h0000_0000, 2'h0);
    wr(slpp_pkg::OFF_POWER, 32'h0000_0005, 2'h0);
    chk("pwr_low", 32'(o_port_power_enable), 32'h0000_000a);
    wr(slpp_pkg::OFF_OWNER, 32'h0000_0055, 2'h0);
    chk("lamps_on", 32'({o_green_port_lamp, o_ownership_lamp}), 32'h0000_003f);
    wr(slpp_pkg::OFF_CTRL, 32'h0000_0000, 2'h0);
    chk("lamps_off", 32'({o_green_port_lamp, o_ownership_lamp}), 32'h0000_00cf);
    oc_cmd <= 4'h1;
    repeat (4) @(posedge i_clk_sys);
    chk("pwr_kept", 32'(o_port_power_enable), 32'h0000_000a);
    rd(slpp_pkg::OFF_IRQ_STATUS, 32'h0000_0001, 2'h0);
    wrap_up();
  end
endmodule : slpp_top_tb

// ===== rtl/slpp_pkg.sv
/*
  slpp_pkg: register map, field positions, reset values and strap encodings
  for the strap, lamp and port-power polarity block.
  assumes: 32-bit AXI4-Lite register access, four downstream ports.
*/
package slpp_pkg;

  localparam int unsigned NUM_PORTS = 4;

  // register byte offsets
  localparam logic [7:0] OFF_POWER      = 8'h00;
  localparam logic [7:0] OFF_OWNER      = 8'h04;
  localparam logic [7:0] OFF_CTRL       = 8'h08;
  localparam logic [7:0] OFF_STATUS     = 8'h0C;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h10;
  localparam logic [7:0] OFF_IRQ_MASK   = 8'h14;

  // control fields
  localparam int unsigned CTRL_LAMPS_ON_BIT = 0;
  localparam int unsigned CTRL_OC_CUT_BIT   = 1;

  // status fields
  localparam int unsigned ST_FIXED_LSB = 0;
  localparam int unsigned ST_NONREM_LSB = 2;
  localparam int unsigned ST_POL_BIT    = 5;
  localparam int unsigned ST_CFG_LSB    = 8;
  localparam int unsigned ST_OC_LSB     = 12;

  // reset values
  localparam logic [3:0] RST_POWER    = 4'h0;
  localparam logic [7:0] RST_OWNER    = 8'h00;
  localparam logic [1:0] RST_CTRL     = 2'h3;
  localparam logic [3:0] RST_IRQ_MASK = 4'h0;

  // configuration method strap codes
  localparam logic [2:0] CFG_DEFAULT_3W    = 3'h0;
  localparam logic [2:0] CFG_SMBUS         = 3'h1;
  localparam logic [2:0] CFG_DEFAULT_4W_LV = 3'h2;
  localparam logic [2:0] CFG_EEPROM        = 3'h3;
  localparam logic [2:0] CFG_DEFAULT_SC    = 3'h4;
  localparam logic [2:0] CFG_DEFAULT_DC    = 3'h5;

  // per-port ownership lamp codes
  localparam logic [1:0] OWN_NONE  = 2'h0;
  localparam logic [1:0] OWN_HOST1 = 2'h1;
  localparam logic [1:0] OWN_HOST2 = 2'h2;
  localparam logic [1:0] OWN_BOTH  = 2'h3;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : slpp_pkg

// ===== rtl/slpp_top.sv
/*
  slpp_top: strap capture at reset release, green and ownership lamp
  polarity and drive, port-power polarity and over-current events,
  with an AXI4-Lite register slave and one level interrupt.
  assumes: pin inputs synchronous to i_clk_sys, pads resolve oe_n.
*/
// The register addresses and the AXI4-Lite interface to the registers are this design's own decisions.
module slpp_top (
  input  wire logic        i_clk_sys,
  input  wire logic        i_sys_rst,
  input  wire logic [7:0]  i_awaddr,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  output logic [1:0]       o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  input  wire logic [7:0]  i_araddr,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  input  wire logic [1:0]  i_fixed_device_strap,
  input  wire logic        i_power_polarity_strap,
  input  wire logic [2:0]  i_config_method_strap,
  input  wire logic [3:0]  i_overcurrent_sense_low,
  output logic [3:0]       o_green_port_lamp,
  output logic [3:0]       o_green_port_lamp_oe_n,
  output logic [3:0]       o_ownership_lamp,
  output logic [3:0]       o_ownership_lamp_oe_n,
  output logic [3:0]       o_port_power_enable,
  output logic             o_irq
);

  function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return (old_v & ~m) | (new_v & m);
  endfunction : merge_strb

  // register offset compare, shared by write and read decode
  function automatic logic addr_is(input logic [7:0] addr,
                                   input logic [7:0] off);
    return (addr == off);
  endfunction : addr_is

  // two-bit ownership code of one port
  function automatic logic [1:0] port_code(input logic [7:0] codes,
                                           input int          p);
    return codes[2*p+:2];
  endfunction : port_code

  // straps and their capture
  logic       strap_taken;
  logic [1:0] fixed_strap;
  logic       pol_strap;
  logic [2:0] cfg_strap;

  // one capture per reset, on the first edge after release
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      strap_taken <= 1'b0;
      fixed_strap <= 2'h0;
      pol_strap   <= 1'b0;
      cfg_strap   <= 3'h0;
    end else if (!strap_taken) begin
      strap_taken <= 1'b1;
      cfg_strap   <= i_config_method_strap;
      pol_strap   <= i_power_polarity_strap;
      fixed_strap <= i_fixed_device_strap;
    end
  end

  wire cfg_internal = (cfg_strap == slpp_pkg::CFG_DEFAULT_3W)
                    | (cfg_strap == slpp_pkg::CFG_DEFAULT_4W_LV)
                    | (cfg_strap == slpp_pkg::CFG_DEFAULT_SC);
  wire dual_color   = (cfg_strap == slpp_pkg::CFG_DEFAULT_DC);
  wire [1:0] eff_fixed = cfg_internal ? fixed_strap : 2'h0;

  // non-removable mask: 00 none, 01 port1, 10 ports 1-2, 11 ports 1-3
  wire [2:0] nonrem_mask = (eff_fixed == 2'h0) ? 3'h0 :
                           (eff_fixed == 2'h1) ? 3'h1 :
                           (eff_fixed == 2'h2) ? 3'h3 :
                                                 3'h7;

  // green lamp active-low per port; with a default config strap other than CFG_DEFAULT_DC, strap bit i sets port i+1 low, else all four are low
  wire [1:0] green_low_12 = cfg_internal ? fixed_strap : 2'h3;
  wire [3:0] green_low    = {2'h3, green_low_12};

  // registers
  logic [3:0]  power_req;
  logic [7:0]  owner;
  logic [1:0]  ctrl;
  logic [3:0]  irq_status;
  logic [3:0]  irq_mask;
  logic [3:0]  oc_prev;

  // axi write path
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;

  // a finished write keeps both readies low until bready
  wire        aw_go     = i_awvalid & o_awready;
  wire        w_go      = i_wvalid & o_wready;
  wire        aw_have   = aw_held | aw_go;
  wire        w_have    = w_held | w_go;
  wire        do_write  = aw_have & w_have & ~o_bvalid;
  wire [7:0]  wr_addr   = aw_held ? aw_addr_q : i_awaddr;
  wire [31:0] wr_data   = w_held ? w_data_q : i_wdata;
  wire [3:0]  wr_strb   = w_held ? w_strb_q : i_wstrb;
  wire        next_aw_held = aw_have & ~do_write;
  wire        next_w_held  = w_have & ~do_write;
  wire        next_bvalid  = do_write | (o_bvalid & ~i_bready);

  wire wr_power  = do_write & addr_is(wr_addr, slpp_pkg::OFF_POWER);
  wire wr_owner  = do_write & addr_is(wr_addr, slpp_pkg::OFF_OWNER);
  wire wr_ctrl   = do_write & addr_is(wr_addr, slpp_pkg::OFF_CTRL);
  wire wr_istat  = do_write & addr_is(wr_addr, slpp_pkg::OFF_IRQ_STATUS);
  wire wr_imask  = do_write & addr_is(wr_addr, slpp_pkg::OFF_IRQ_MASK);
  wire wr_status = do_write & addr_is(wr_addr, slpp_pkg::OFF_STATUS);
  wire wr_hit    = wr_power | wr_owner | wr_ctrl | wr_istat | wr_imask | wr_status;

  wire [31:0] m_power = merge_strb({28'h000_0000, power_req}, wr_data, wr_strb);
  wire [31:0] m_owner = merge_strb({24'h00_0000, owner}, wr_data, wr_strb);
  wire [31:0] m_ctrl  = merge_strb({30'h0000_0000, ctrl}, wr_data, wr_strb);
  wire [31:0] m_imask = merge_strb({28'h000_0000, irq_mask}, wr_data, wr_strb);
  wire [3:0]  w1c     = (wr_istat & wr_strb[0]) ? wr_data[3:0] : 4'h0;

  // over-current events: falling edge of each active-low sense input
  wire [3:0] oc_active = ~i_overcurrent_sense_low;
  wire [3:0] oc_event  = oc_prev & ~i_overcurrent_sense_low & {4{strap_taken}};
  wire [3:0] next_irq_status = (irq_status & ~w1c) | oc_event; // set wins over clear

  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      aw_held   <= 1'b0;
      w_held    <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
      o_awready <= 1'b0;
      o_wready  <= 1'b0;
      o_bvalid  <= 1'b0;
      o_bresp   <= slpp_pkg::RESP_OKAY;
    end else begin
      aw_held   <= next_aw_held;
      w_held    <= next_w_held;
      o_awready <= ~next_aw_held & ~next_bvalid;
      o_wready  <= ~next_w_held & ~next_bvalid;
      o_bvalid  <= next_bvalid;
      if (aw_go) begin
        aw_addr_q <= i_awaddr;
      end
      if (w_go) begin
        w_data_q <= i_wdata;
        w_strb_q <= i_wstrb;
      end
      if (do_write) begin
        o_bresp <= wr_hit ? slpp_pkg::RESP_OKAY : slpp_pkg::RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      power_req  <= slpp_pkg::RST_POWER;
      owner      <= slpp_pkg::RST_OWNER;
      ctrl       <= slpp_pkg::RST_CTRL;
      irq_mask   <= slpp_pkg::RST_IRQ_MASK;
      irq_status <= 4'h0;
      oc_prev    <= 4'hF;
      o_irq      <= 1'b0;
    end else begin
      if (wr_power) power_req <= m_power[3:0];
      if (wr_owner) owner <= m_owner[7:0];
      if (wr_ctrl) ctrl <= m_ctrl[1:0];
      if (wr_imask) irq_mask <= m_imask[3:0];
      irq_status <= next_irq_status;
      oc_prev    <= i_overcurrent_sense_low;
      o_irq      <= |(next_irq_status & irq_mask);
    end
  end

  // axi read path
  // arready stays low while an answer waits for rready
  wire ar_go       = i_arvalid & o_arready;
  wire next_rvalid = ar_go | (o_rvalid & ~i_rready);

  // read-only view of the captured straps and live sense inputs
  logic [31:0] status_word;
  always_comb begin
    status_word                               = 32'h0000_0000;
    status_word[slpp_pkg::ST_FIXED_LSB +: 2]  = eff_fixed;
    status_word[slpp_pkg::ST_NONREM_LSB +: 3] = nonrem_mask;
    status_word[slpp_pkg::ST_POL_BIT]         = pol_strap;
    status_word[slpp_pkg::ST_CFG_LSB +: 3]    = cfg_strap;
    status_word[slpp_pkg::ST_OC_LSB +: 4]     = oc_active;
  end
  wire        rd_power  = addr_is(i_araddr, slpp_pkg::OFF_POWER);
  wire        rd_owner  = addr_is(i_araddr, slpp_pkg::OFF_OWNER);
  wire        rd_ctrl   = addr_is(i_araddr, slpp_pkg::OFF_CTRL);
  wire        rd_status = addr_is(i_araddr, slpp_pkg::OFF_STATUS);
  wire        rd_istat  = addr_is(i_araddr, slpp_pkg::OFF_IRQ_STATUS);
  wire        rd_imask  = addr_is(i_araddr, slpp_pkg::OFF_IRQ_MASK);
  wire        rd_hit    = rd_power | rd_owner | rd_ctrl | rd_status | rd_istat | rd_imask;
  wire [31:0] rd_word   = rd_power  ? {28'h000_0000, power_req}  :
                          rd_owner  ? {24'h00_0000, owner}       :
                          rd_ctrl   ? {30'h0000_0000, ctrl}      :
                          rd_status ? status_word                :
                          rd_istat  ? {28'h000_0000, irq_status} :
                          rd_imask  ? {28'h000_0000, irq_mask}   :
                                      32'h0000_0000;

  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b0;
      o_rdata   <= 32'h0000_0000;
      o_rresp   <= slpp_pkg::RESP_OKAY;
    end else begin
      o_arready <= ~next_rvalid;
      o_rvalid  <= next_rvalid;
      if (ar_go) begin
        o_rdata <= rd_word;
        o_rresp <= rd_hit ? slpp_pkg::RESP_OKAY : slpp_pkg::RESP_SLVERR;
      end
    end
  end

  // lamp decode per port: green on A pin, other host on B pin
  logic [3:0] green_on;
  logic [3:0] own_on;
  always_comb begin
    for (int p = 0; p < slpp_pkg::NUM_PORTS; p++) begin
      if (dual_color) begin
        green_on[p] = owner[2*p] | (port_code(owner, p) == slpp_pkg::OWN_BOTH);
        own_on[p]   = owner[2*p+1];
      end else begin
        green_on[p] = (port_code(owner, p) == slpp_pkg::OWN_HOST1);
        own_on[p]   = (port_code(owner, p) == slpp_pkg::OWN_HOST2);
      end
    end
  end

  wire [3:0] lamps_gate = {4{ctrl[slpp_pkg::CTRL_LAMPS_ON_BIT]}};
  wire [3:0] next_green = (green_on & lamps_gate) ^ green_low;
  wire [3:0] next_own   = ~(own_on & lamps_gate);

  // port power: request gated by over-current status when enabled
  wire [3:0] oc_cut   = irq_status & {4{ctrl[slpp_pkg::CTRL_OC_CUT_BIT]}};
  logic [3:0] power_on;

  // oe_n drops one edge after capture so straps are never overdriven
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_green_port_lamp      <= 4'h0;
      o_green_port_lamp_oe_n <= 4'hF;
      o_ownership_lamp       <= 4'hF;
      o_ownership_lamp_oe_n  <= 4'hF;
      power_on               <= 4'h0;
    end else begin
      o_green_port_lamp      <= next_green;
      o_green_port_lamp_oe_n <= {4{~strap_taken}};
      o_ownership_lamp       <= next_own;
      o_ownership_lamp_oe_n  <= {4{~strap_taken}};
      power_on               <= power_req & ~oc_cut & {4{strap_taken}};
    end
  end

  // polarity follows the live strap pin until the capture edge, so the
  // cycle between release and capture cannot flip port power on
  wire pol_from_pin = i_sys_rst | ~strap_taken;
  wire pol_eff      = pol_from_pin ? i_power_polarity_strap : pol_strap;
  wire [3:0] power_live = i_sys_rst ? 4'h0 : power_on;
  assign o_port_power_enable = pol_eff ? power_live : ~power_live;

endmodule : slpp_top
